// *** logic/lsif_cfg.svh ***
// Register offsets, field positions and reset values of the status block.
`ifndef LSIF_CFG_SVH
`define LSIF_CFG_SVH

`define LSIF_ADDR_W          8
`define LSIF_OFS_TX_BASE     8'h20
`define LSIF_OFS_STATUS      8'h28
`define LSIF_OFS_MASK        8'h38
`define LSIF_BIT_TX_DONE     0
`define LSIF_BIT_TX_STOP     1
`define LSIF_BIT_TX_BUF      2
`define LSIF_BIT_TX_JAB      3
`define LSIF_BIT_SPARE_LO    4
`define LSIF_BIT_TX_UNF      5
`define LSIF_BIT_RX_DONE     6
`define LSIF_BIT_RX_BUF      7
`define LSIF_BIT_RX_STOP     8
`define LSIF_BIT_RX_WDT      9
`define LSIF_BIT_EARLY_TX    10
`define LSIF_BIT_GP_TIMER    11
`define LSIF_BIT_SPARE_HI    12
`define LSIF_BIT_BUS_ERR     13
`define LSIF_BIT_EARLY_RX    14
`define LSIF_BIT_ABN_SUM     15
`define LSIF_BIT_NRM_SUM     16
`define LSIF_RX_CODE_LO      17
`define LSIF_TX_CODE_LO      20
`define LSIF_ERR_CODE_LO     23
`define LSIF_FLAG_W          15
`define LSIF_NORMAL_SET      15'h4845
`define LSIF_ABNORMAL_SET    15'h07AA
`define LSIF_FLAG_USED       15'h6FEF
`define LSIF_STATUS_TOP      32'hFC000000
`define LSIF_MASK_RESET      15'h0000
`define LSIF_BASE_RESET      30'h00000000
`define LSIF_RX_SUSPENDED    3'h4
`define LSIF_TX_SUSPENDED    3'h6
`define LSIF_TX_STOPPED      3'h0

`endif

// *** logic/lsif_pkg.sv ***
// Types shared by the status and interrupt flag block.
package lsif_pkg;
	typedef logic [2:0] lsif_code_type;
	typedef logic [14:0] lsif_flag_type;
	typedef logic [31:0] lsif_word_type;
	typedef enum logic [0:0] {
		LSIF_IDLE = 1'b0,
		LSIF_ACK  = 1'b1
	} lsif_bus_type;
endpackage

// *** logic/lsif_status.sv ***
// Status flags, interrupt summaries and transmit list base over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "lsif_cfg.svh"

module lsif_status (
	// Clock and reset.
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Wishbone slave.
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	// Events from the DMA engines, one-cycle pulses.
	input  wire logic                   ev_tx_done,
	input  wire logic                   ev_tx_stopped,
	input  wire logic                   ev_tx_buf_unavail,
	input  wire logic                   ev_tx_jabber,
	input  wire logic                   ev_tx_underflow,
	input  wire logic                   ev_rx_done,
	input  wire logic                   ev_rx_buf_unavail,
	input  wire logic                   ev_rx_stopped,
	input  wire logic                   ev_early_tx,
	input  wire logic                   ev_gp_timer,
	input  wire logic                   ev_bus_error,
	input  wire logic                   ev_early_rx,
	input  wire logic [2:0]             ev_bus_error_type,
	// Line status level for the receive watchdog.
	input  wire logic                   rx_watchdog_line,
	// Process state codes from the DMA engines.
	input  wire lsif_pkg::lsif_code_type tx_process_code,
	input  wire lsif_pkg::lsif_code_type rx_process_code,
	// Control outputs to the DMA engines and host.
	output logic      [31:0]            tx_list_base,
	output logic                        bus_master_enable,
	output logic                        tx_suspend_req,
	output logic                        tx_stop_req,
	output logic                        tx_desc_underflow_mark,
	output logic                        rx_suspend_req,
	output logic                        irq
);
	import lsif_pkg::*;

	lsif_flag_type flags_ff;
	lsif_flag_type mask_ff;
	lsif_flag_type set_vec;
	lsif_flag_type clr_vec;
	lsif_code_type bus_error_type_ff;
	logic [29:0]   base_ff;
	logic          watchdog_meta_ff;
	logic          watchdog_sync_ff;
	logic          rx_owned_prev_ff;
	logic          rx_buf_set;
	lsif_bus_type  bus_state_ff;
	logic          bus_req;
	logic          wr_take;
	logic          normal_summary;
	logic          abnormal_summary;
	lsif_word_type status_word;
	logic          tx_suspend_ff;
	logic          tx_stop_ff;
	logic          tx_mark_ff;
	logic          rx_suspend_ff;

	// Ack rises one edge after the request; writes land at the ack edge.
	assign bus_req = wb_cyc_i && wb_stb_i && (bus_state_ff == LSIF_IDLE);
	assign wr_take = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_state_ff <= LSIF_IDLE;
		end else begin
			case (bus_state_ff)
				LSIF_IDLE: begin
					if (bus_req) begin
						bus_state_ff <= LSIF_ACK;
					end
				end
				LSIF_ACK: begin
					bus_state_ff <= LSIF_IDLE;
				end
				default: begin
					bus_state_ff <= LSIF_IDLE;
				end
			endcase
		end
	end

	assign wb_ack_o = (bus_state_ff == LSIF_ACK);

	// The line status comes from the receive front end, so synchronise it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_meta_ff <= 1'b0;
			watchdog_sync_ff <= 1'b0;
		end else begin
			watchdog_meta_ff <= rx_watchdog_line;
			watchdog_sync_ff <= watchdog_meta_ff;
		end
	end

	// Suspension already reported is not reported again on later fetches.
	assign rx_buf_set = ev_rx_buf_unavail && rx_owned_prev_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_owned_prev_ff <= 1'b1;
		end else if (ev_rx_buf_unavail) begin
			rx_owned_prev_ff <= 1'b0;
		end else if (rx_process_code != `LSIF_RX_SUSPENDED) begin
			rx_owned_prev_ff <= 1'b1;
		end
	end

	always_comb begin
		set_vec = '0;
		set_vec[`LSIF_BIT_TX_DONE]  = ev_tx_done;
		set_vec[`LSIF_BIT_TX_STOP]  = ev_tx_stopped;
		set_vec[`LSIF_BIT_TX_BUF]   = ev_tx_buf_unavail;
		set_vec[`LSIF_BIT_TX_JAB]   = ev_tx_jabber;
		set_vec[`LSIF_BIT_TX_UNF]   = ev_tx_underflow;
		set_vec[`LSIF_BIT_RX_DONE]  = ev_rx_done;
		set_vec[`LSIF_BIT_RX_BUF]   = rx_buf_set;
		set_vec[`LSIF_BIT_RX_STOP]  = ev_rx_stopped;
		set_vec[`LSIF_BIT_RX_WDT]   = watchdog_sync_ff;
		set_vec[`LSIF_BIT_EARLY_TX] = ev_early_tx && !ev_tx_done;
		set_vec[`LSIF_BIT_GP_TIMER] = ev_gp_timer;
		set_vec[`LSIF_BIT_BUS_ERR]  = ev_bus_error;
		set_vec[`LSIF_BIT_EARLY_RX] = ev_early_rx && !ev_rx_done;
	end

	always_comb begin
		clr_vec = '0;
		if (wr_take && wb_adr_i == `LSIF_OFS_STATUS) begin
			if (wb_sel_i[0]) begin
				clr_vec[7:0] = wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				clr_vec[14:8] = wb_dat_i[14:8];
			end
		end
		clr_vec[`LSIF_BIT_EARLY_RX] = clr_vec[`LSIF_BIT_EARLY_RX] || ev_rx_done;
		clr_vec[`LSIF_BIT_EARLY_TX] = clr_vec[`LSIF_BIT_EARLY_TX] || ev_tx_done;
	end

	// Every flag is its own sticky cell with write-one clear.
	lsif_flag_cell u_flag_tx_done (
		.clk     (clk),
		.rst_n   (rst_n),
		.set_in  (set_vec[`LSIF_BIT_TX_DONE]),
		.clr_in  (clr_vec[`LSIF_BIT_TX_DONE]),
		.flag_ff (flags_ff[`LSIF_BIT_TX_DONE])
	);
	lsif_flag_cell u_flag_tx_stop (
		.clk     (clk),
		.rst_n   (rst_n),
		.set_in  (set_vec[`LSIF_BIT_TX_STOP]),
		.clr_in  (clr_vec[`LSIF_BIT_TX_STOP]),
		.flag_ff (flags_ff[`LSIF_BIT_TX_STOP])
	);
	lsif_flag_cell u_flag_tx_buf (
		.clk     (clk),
		.rst_n   (rst_n),
		.set_in  (set_vec[`LSIF_BIT_TX_BUF]),
		.clr_in  (clr_vec[`LSIF_BIT_TX_BUF]),
		.flag_ff (flags_ff[`LSIF_BIT_TX_BUF])
	);
	lsif_flag_cell u_flag_tx_jab (
		.clk     (clk),
		.rst_n   (rst_n),
		.set_in  (set_vec[`LSIF_BIT_TX_JAB]),
		.clr_in  (clr_vec[`LSIF_BIT_TX_JAB]),
		.flag_ff (flags_ff[`LSIF_BIT_TX_JAB])
	);
	lsif_flag_cell u_flag_tx_unf (
		.clk     (clk),
		.rst_n   (rst_n),
		.set_in  (set_vec[`LSIF_BIT_TX_UNF]),
		.clr_in  (clr_vec[`LSIF_BIT_TX_UNF]),
		.flag_ff (flags_ff[`LSIF_BIT_TX_UNF])
	);
	lsif_flag_cell u_flag_rx_done (
		.clk     (clk),
		.rst_n   (rst_n),
		.set_in  (set_vec[`LSIF_BIT_RX_DONE]),
		.clr_in  (clr_vec[`LSIF_BIT_RX_DONE]),
		.flag_ff (flags_ff[`LSIF_BIT_RX_DONE])
	);
	lsif_flag_cell u_flag_rx_buf (
		.clk     (clk),
		.rst_n   (rst_n),
		.set_in  (set_vec[`LSIF_BIT_RX_BUF]),
		.clr_in  (clr_vec[`LSIF_BIT_RX_BUF]),
		.flag_ff (flags_ff[`LSIF_BIT_RX_BUF])
	);
	lsif_flag_cell u_flag_rx_stop (
		.clk     (clk),
		.rst_n   (rst_n),
		.set_in  (set_vec[`LSIF_BIT_RX_STOP]),
		.clr_in  (clr_vec[`LSIF_BIT_RX_STOP]),
		.flag_ff (flags_ff[`LSIF_BIT_RX_STOP])
	);
	lsif_flag_cell u_flag_rx_wdt (
		.clk     (clk),
		.rst_n   (rst_n),
		.set_in  (set_vec[`LSIF_BIT_RX_WDT]),
		.clr_in  (clr_vec[`LSIF_BIT_RX_WDT]),
		.flag_ff (flags_ff[`LSIF_BIT_RX_WDT])
	);
	lsif_flag_cell u_flag_early_tx (
		.clk     (clk),
		.rst_n   (rst_n),
		.set_in  (set_vec[`LSIF_BIT_EARLY_TX]),
		.clr_in  (clr_vec[`LSIF_BIT_EARLY_TX]),
		.flag_ff (flags_ff[`LSIF_BIT_EARLY_TX])
	);
	lsif_flag_cell u_flag_gp_timer (
		.clk     (clk),
		.rst_n   (rst_n),
		.set_in  (set_vec[`LSIF_BIT_GP_TIMER]),
		.clr_in  (clr_vec[`LSIF_BIT_GP_TIMER]),
		.flag_ff (flags_ff[`LSIF_BIT_GP_TIMER])
	);
	lsif_flag_cell u_flag_bus_err (
		.clk     (clk),
		.rst_n   (rst_n),
		.set_in  (set_vec[`LSIF_BIT_BUS_ERR]),
		.clr_in  (clr_vec[`LSIF_BIT_BUS_ERR]),
		.flag_ff (flags_ff[`LSIF_BIT_BUS_ERR])
	);
	lsif_flag_cell u_flag_early_rx (
		.clk     (clk),
		.rst_n   (rst_n),
		.set_in  (set_vec[`LSIF_BIT_EARLY_RX]),
		.clr_in  (clr_vec[`LSIF_BIT_EARLY_RX]),
		.flag_ff (flags_ff[`LSIF_BIT_EARLY_RX])
	);

	// The two reserved positions carry no flag and always read as zero.
	assign flags_ff[`LSIF_BIT_SPARE_LO] = 1'b0;
	assign flags_ff[`LSIF_BIT_SPARE_HI] = 1'b0;

	// The error kind is caught with the error and held until the next one.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_error_type_ff <= '0;
		end else if (ev_bus_error) begin
			bus_error_type_ff <= ev_bus_error_type;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_ff <= `LSIF_MASK_RESET;
		end else if (wr_take && wb_adr_i == `LSIF_OFS_MASK) begin
			if (wb_sel_i[0]) begin
				mask_ff[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				mask_ff[14:8] <= wb_dat_i[14:8];
			end
		end
	end

	// Software owns alignment; the low two bits are not stored at all.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			base_ff <= `LSIF_BASE_RESET;
		end else if (wr_take && wb_adr_i == `LSIF_OFS_TX_BASE) begin
			if (wb_sel_i[0]) begin
				base_ff[5:0] <= wb_dat_i[7:2];
			end
			if (wb_sel_i[1]) begin
				base_ff[13:6] <= wb_dat_i[15:8];
			end
			if (wb_sel_i[2]) begin
				base_ff[21:14] <= wb_dat_i[23:16];
			end
			if (wb_sel_i[3]) begin
				base_ff[29:22] <= wb_dat_i[31:24];
			end
		end
	end

	assign tx_list_base = {base_ff, 2'b00};

	// A mask bit of one lets any flag except bus error through to the summaries.
	assign normal_summary = |(flags_ff & mask_ff & `LSIF_NORMAL_SET);
	assign abnormal_summary = |(flags_ff & mask_ff & `LSIF_ABNORMAL_SET);
	assign irq = normal_summary || abnormal_summary;

	always_comb begin
		status_word = `LSIF_STATUS_TOP;
		status_word[`LSIF_FLAG_W-1:0] = flags_ff;
		status_word[`LSIF_BIT_ABN_SUM] = abnormal_summary;
		status_word[`LSIF_BIT_NRM_SUM] = normal_summary;
		status_word[`LSIF_RX_CODE_LO+:3] = rx_process_code;
		status_word[`LSIF_TX_CODE_LO+:3] = tx_process_code;
		status_word[`LSIF_ERR_CODE_LO+:3] = bus_error_type_ff;
	end

	// Unmapped addresses answer with zero data, so the bus never hangs.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= '0;
		end else if (bus_req && !wb_we_i) begin
			case (wb_adr_i)
				`LSIF_OFS_STATUS:  wb_dat_o <= status_word;
				`LSIF_OFS_TX_BASE: wb_dat_o <= tx_list_base;
				`LSIF_OFS_MASK:    wb_dat_o <= {17'h00000, mask_ff};
				default:           wb_dat_o <= '0;
			endcase
		end
	end

	// Engine controls are registered one edge after the causing event.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_suspend_ff <= 1'b0;
			tx_stop_ff    <= 1'b0;
			tx_mark_ff    <= 1'b0;
			rx_suspend_ff <= 1'b0;
		end else begin
			tx_suspend_ff <= ev_tx_underflow || ev_tx_buf_unavail;
			tx_stop_ff    <= ev_tx_jabber;
			tx_mark_ff    <= ev_tx_underflow;
			rx_suspend_ff <= ev_rx_buf_unavail;
		end
	end

	assign tx_suspend_req = tx_suspend_ff;
	assign tx_stop_req = tx_stop_ff;
	assign tx_desc_underflow_mark = tx_mark_ff;
	assign rx_suspend_req = rx_suspend_ff;
	// Mastering stays off until software clears the fatal flag.
	assign bus_master_enable = !flags_ff[`LSIF_BIT_BUS_ERR];

endmodule // lsif_status

module lsif_flag_cell (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_n,
	// Event and write-one clear of this flag.
	input  wire logic set_in,
	input  wire logic clr_in,
	// Sticky flag as read by software.
	output logic      flag_ff
);
	// A new event wins over a clear arriving in the same cycle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_ff <= 1'b0;
		end else begin
			flag_ff <= set_in || (flag_ff && !clr_in);
		end
	end

endmodule // lsif_flag_cell

`default_nettype wire

// *** sim/lsif_status_props.sv ***
// Port-level checks for the status and interrupt flag block.
`timescale 1ns/1ps
`default_nettype none
`include "lsif_cfg.svh"
module lsif_status_props (
	// Clock and reset.
	input wire logic                    clk,
	input wire logic                    rst_n,
	// Wishbone slave side.
	input wire logic                    wb_cyc_i,
	input wire logic                    wb_stb_i,
	input wire logic                    wb_we_i,
	input wire logic [7:0]              wb_adr_i,
	input wire logic [3:0]              wb_sel_i,
	input wire logic [31:0]             wb_dat_i,
	input wire logic [31:0]             wb_dat_o,
	input wire logic                    wb_ack_o,
	// Events and process codes.
	input wire logic                    ev_tx_jabber,
	input wire logic                    ev_tx_underflow,
	input wire logic                    ev_tx_buf_unavail,
	input wire logic                    ev_rx_buf_unavail,
	input wire logic                    ev_bus_error,
	input wire lsif_pkg::lsif_code_type tx_process_code,
	input wire lsif_pkg::lsif_code_type rx_process_code,
	// Control outputs.
	input wire logic [31:0]             tx_list_base,
	input wire logic                    bus_master_enable,
	input wire logic                    tx_suspend_req,
	input wire logic                    tx_stop_req,
	input wire logic                    tx_desc_underflow_mark,
	input wire logic                    rx_suspend_req,
	input wire logic                    irq
);
	import lsif_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in one cycle");
	a_base_aligned: assert property (tx_list_base[1:0] == 2'b00)
		else $error("list base low bits not zero");
	a_base_write: assert property (wb_ack_o && wb_we_i
		&& wb_adr_i == `LSIF_OFS_TX_BASE && wb_sel_i == 4'hF
		|=> tx_list_base == ($past(wb_dat_i) & 32'hFFFFFFFC))
		else $error("list base write not stored");
	a_rx_suspend: assert property (ev_rx_buf_unavail |=> rx_suspend_req)
		else $error("unavailable receive buffer did not suspend");
	a_bus_stop: assert property (ev_bus_error |-> ##[1:2] !bus_master_enable)
		else $error("bus master still enabled after bus error");
	a_jabber_stop: assert property (ev_tx_jabber |=> tx_stop_req)
		else $error("jabber did not stop transmit");
	a_unf_suspend: assert property (ev_tx_underflow |=> tx_suspend_req && tx_desc_underflow_mark)
		else $error("underflow did not suspend and mark");
	a_txbuf_suspend: assert property (ev_tx_buf_unavail |=> tx_suspend_req)
		else $error("unavailable descriptor did not suspend");
	a_status_codes: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `LSIF_OFS_STATUS |-> wb_dat_o[31:26] == 6'h3F && wb_dat_o[22:17] == {$past(tx_process_code), $past(rx_process_code)})
		else $error("status code fields wrong");
	a_irq_summary: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `LSIF_OFS_STATUS |-> $past(irq) == (wb_dat_o[16] | wb_dat_o[15]))
		else $error("irq differs from summaries");
endmodule // lsif_status_props
`default_nettype wire

// *** sim/lsif_host.sv ***
// Host driver model: classic Wishbone master cycles.
`timescale 1ns/1ps
`default_nettype none
module lsif_host (
	// Clock.
	input wire logic         clk,
	// Master side.
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [7:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      dat,
	input  wire logic [31:0] rdat,
	input  wire logic        ack
);
	initial {cyc, stb, we, adr, sel, dat} = '0;
	// Released lines show inverted data so stale values never look valid.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		{cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hF, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		{cyc, stb, adr, dat} <= {2'b00, ~a, ~d};
	endtask
endmodule // lsif_host
`default_nettype wire

// *** sim/lsif_status_tb_top.sv ***
// Self-checking bench for the status and interrupt flag block.
`timescale 1ns/1ps
`default_nettype none
`include "lsif_cfg.svh"
module lsif_status_tb_top;
	import lsif_pkg::*;
	logic          clk, rst_n, cyc, stb, we, ack, irq, bme, wdl;
	logic [7:0]    adr;
	logic [3:0]    sel;
	logic [31:0]   dat, rdat, q, r, base, seed;
	logic [14:0]   ev, flags, mask;
	logic [2:0]    etype, m_etype;
	lsif_code_type txc, rxc;
	int            fails, tests_run, cyc_n;
	lsif_host u_lsif_host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat(dat), .rdat(rdat), .ack(ack));
	lsif_status u_lsif_status (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .ev_tx_done(ev[0]),
		.ev_tx_stopped(ev[1]), .ev_tx_buf_unavail(ev[2]), .ev_tx_jabber(ev[3]),
		.ev_tx_underflow(ev[5]), .ev_rx_done(ev[6]), .ev_rx_buf_unavail(ev[7]),
		.ev_rx_stopped(ev[8]), .ev_early_tx(ev[10]), .ev_gp_timer(ev[11]),
		.ev_bus_error(ev[13]), .ev_early_rx(ev[14]), .ev_bus_error_type(etype),
		.rx_watchdog_line(wdl), .tx_process_code(txc), .rx_process_code(rxc),
		.tx_list_base(base), .bus_master_enable(bme), .tx_suspend_req(),
		.tx_stop_req(), .tx_desc_underflow_mark(), .rx_suspend_req(), .irq(irq));
	function automatic logic [31:0] nxt();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] exp_st();
		logic [14:0] u;
		u = flags & mask;
		return {6'h3F, m_etype, txc, rxc, |(u & `LSIF_NORMAL_SET),
			|(u & `LSIF_ABNORMAL_SET), flags};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		tests_run++;
		if (got !== e) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_lsif_host.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		u_lsif_host.xfer(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	// Done events wipe the matching early flag, whether it was raised earlier or in the same cycle.
	task automatic pulse(input logic [14:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= '0;
		flags = (flags | v) & ~{v[6], 3'b000, v[0], 10'h000};
		if (v[13]) m_etype = etype;
	endtask
	task automatic print_verdict();
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			fails++;
			print_verdict();
		end
	end
	initial begin
		{rst_n, wdl, ev, etype, txc, rxc, flags, mask, m_etype} = '0;
		seed = 32'h5C7F;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(`LSIF_OFS_STATUS, exp_st());
		rd(`LSIF_OFS_MASK, 32'h0);
		rd(8'h04, 32'h0);
		r = nxt();
		wr(`LSIF_OFS_TX_BASE, {r[31:2], 2'b00});
		rd(`LSIF_OFS_TX_BASE, {r[31:2], 2'b00});
		chk(base, {r[31:2], 2'b00});
		r = nxt();
		mask = r[14:0] & `LSIF_FLAG_USED;
		wr(`LSIF_OFS_MASK, {17'h0, mask});
		rd(`LSIF_OFS_MASK, {17'h0, mask});
		for (int i = 0; i < 15; i++) begin
			if (i == 9 || !((`LSIF_FLAG_USED >> i) & 1)) continue;
			r = nxt();
			etype <= r[2:0];
			txc <= r[5:3];
			rxc <= {1'b0, r[7:6]};
			pulse(15'h1 << i);
			rd(`LSIF_OFS_STATUS, exp_st());
			chk({31'h0, irq}, {31'h0, |(exp_st() & 32'h00018000)});
			chk({31'h0, bme}, {31'h0, !flags[13]});
			wr(`LSIF_OFS_STATUS, 32'h0);
			rd(`LSIF_OFS_STATUS, exp_st());
			wr(`LSIF_OFS_STATUS, 32'hFFFE0000 | (32'h1 << i));
			flags[i] = 1'b0;
			rd(`LSIF_OFS_STATUS, exp_st());
		end
		pulse(15'h4000);
		pulse(15'h0040);
		rd(`LSIF_OFS_STATUS, exp_st());
		pulse(15'h0400);
		pulse(15'h0001);
		pulse(15'h4040);
		rd(`LSIF_OFS_STATUS, exp_st());
		wdl <= 1'b1;
		repeat (4) @(posedge clk);
		wdl <= 1'b0;
		flags[9] = 1'b1;
		rd(`LSIF_OFS_STATUS, exp_st());
		wr(`LSIF_OFS_STATUS, 32'hFFFFFFFF);
		flags = '0;
		rxc <= 3'h4;
		pulse(15'h0080);
		wr(`LSIF_OFS_STATUS, 32'h80);
		pulse(15'h0080);
		flags[7] = 1'b0;
		rd(`LSIF_OFS_STATUS, exp_st());
		rxc <= 3'h3;
		pulse(15'h0080);
		rd(`LSIF_OFS_STATUS, exp_st());
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		chk(base, 32'h0);
		chk({30'h0, bme, irq}, 32'h2);
		rst_n <= 1'b1;
		{flags, mask, m_etype} = '0;
		rd(`LSIF_OFS_STATUS, exp_st());
		rd(`LSIF_OFS_MASK, 32'h0);
		print_verdict();
	end
endmodule // lsif_status_tb_top
bind lsif_status lsif_status_props u_lsif_status_props (.clk(clk),
	.rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.ev_tx_jabber(ev_tx_jabber), .ev_tx_underflow(ev_tx_underflow),
	.ev_tx_buf_unavail(ev_tx_buf_unavail), .ev_bus_error(ev_bus_error),
	.ev_rx_buf_unavail(ev_rx_buf_unavail),
	.tx_process_code(tx_process_code), .rx_process_code(rx_process_code),
	.tx_list_base(tx_list_base), .bus_master_enable(bus_master_enable),
	.tx_suspend_req(tx_suspend_req), .tx_stop_req(tx_stop_req),
	.tx_desc_underflow_mark(tx_desc_underflow_mark),
	.rx_suspend_req(rx_suspend_req), .irq(irq));
`default_nettype wire
